/* rtl/rhc_pkg.sv */
// Constants shared by the record header and command register block
package rhc_pkg;

	// Timing
	localparam int unsigned CLK_PERIOD_NS   = 8;
	localparam int unsigned SECOND_NS       = 1_000_000_000;
	localparam int unsigned CYCLES_PER_SEC  = SECOND_NS / CLK_PERIOD_NS;

	// Serial frame layout
	localparam int          FRAME_BITS      = 16;
	localparam int          FRAME_WR_BIT    = 15;
	localparam int          FRAME_ADDR_HI   = 14;
	localparam int          FRAME_ADDR_LO   = 8;

	// Register addresses, 7-bit byte address of the low byte
	localparam logic [6:0]  ADDR_PAGE       = 7'h00;
	localparam logic [6:0]  ADDR_TEMP       = 7'h0a;
	localparam logic [6:0]  ADDR_REC_PTR    = 7'h14;
	localparam logic [6:0]  ADDR_GW_PART    = 7'h16;
	localparam logic [6:0]  ADDR_GW_LOT_1   = 7'h1a;
	localparam logic [6:0]  ADDR_GW_LOT_2   = 7'h1c;
	localparam logic [6:0]  ADDR_DIAG       = 7'h34;
	localparam logic [6:0]  ADDR_GLOB_CMD   = 7'h36;
	localparam logic [6:0]  ADDR_X_FLAGS    = 7'h38;
	localparam logic [6:0]  ADDR_Y_FLAGS    = 7'h3a;
	localparam logic [6:0]  ADDR_X_PEAK     = 7'h3c;
	localparam logic [6:0]  ADDR_Y_PEAK     = 7'h3e;
	localparam logic [6:0]  ADDR_SEC_LOW    = 7'h40;
	localparam logic [6:0]  ADDR_SEC_HIGH   = 7'h42;
	localparam logic [6:0]  ADDR_X_BIN      = 7'h44;
	localparam logic [6:0]  ADDR_Y_BIN      = 7'h46;
	localparam logic [6:0]  ADDR_SET_A      = 7'h4c;
	localparam logic [6:0]  ADDR_SET_B      = 7'h4e;
	localparam logic [6:0]  ADDR_NODE_LOT_1 = 7'h68;
	localparam logic [6:0]  ADDR_NODE_LOT_2 = 7'h6a;

	// Pages
	localparam logic [7:0]  PAGE_GATEWAY    = 8'h00;
	localparam logic [7:0]  PAGE_NODE_LAST  = 8'h06;

	// Field positions of record_settings_a
	localparam int          SET_RATE_LO     = 14;
	localparam int          SET_WIN_LO      = 12;
	localparam int          SET_RANGE_LO    = 10;
	localparam int          SET_AVG_LO      = 0;

	// Reset values
	localparam logic [15:0] RST_SET_A       = 16'h0008;
	localparam logic [15:0] RST_SET_B       = 16'h0000;
	localparam logic [15:0] RST_SECONDS     = 16'h0000;
	localparam logic [15:0] TEMP_ZERO_CODE  = 16'h11e8;

	// Global command bit positions
	localparam int          CMD_AUTONULL_CLR = 15;
	localparam int          CMD_ALARM_FETCH  = 14;
	localparam int          CMD_REC_FETCH    = 13;
	localparam int          CMD_ALARM_SAVE   = 12;
	localparam int          CMD_REC_TOGGLE   = 11;
	localparam int          CMD_BUF_PTR_ZERO = 10;
	localparam int          CMD_ALARM_ERASE  = 9;
	localparam int          CMD_CLEAR_RECS   = 8;
	localparam int          CMD_SOFT_RESET   = 7;
	localparam int          CMD_SAVE_FLASH   = 6;
	localparam int          CMD_FLASH_TEST   = 5;
	localparam int          CMD_DIAG_CLEAR   = 4;
	localparam int          CMD_FACTORY      = 3;
	localparam int          CMD_SELF_TEST    = 2;
	localparam int          CMD_POWER_DOWN   = 1;
	localparam int          CMD_AUTONULL     = 0;

	// Diagnostic flag positions
	localparam int          DIAG_SELF_TEST  = 5;
	localparam int          DIAG_FLASH_TEST = 6;

endpackage

/* rtl/rhc_spi_frame.sv */
// Serial slave framing: 16-bit frames in, one word shifted out per frame
`timescale 1ns/1ns
module rhc_spi_frame
	import rhc_pkg::*;
(
	// System
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// Serial pins
	input  wire logic        sclk_in,
	input  wire logic        cs_n_in,
	input  wire logic        mosi_in,
	output logic             miso_out,
	// Frame side
	input  wire logic [15:0] tx_word_in,
	output logic             frame_valid_out,
	output logic [15:0]      frame_word_out
);

	logic        sclk_q;
	logic        cs_n_q;
	logic [15:0] rx_sr;
	logic [15:0] tx_sr;
	logic [3:0]  bit_cnt;
	logic        sclk_rise;
	logic        sclk_fall;

	assign sclk_rise = sclk_in & ~sclk_q;
	assign sclk_fall = ~sclk_in & sclk_q;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sclk_q <= 1'b1;
			cs_n_q <= 1'b1;
		end else begin
			sclk_q <= sclk_in;
			cs_n_q <= cs_n_in;
		end
	end

	// Sample on rising clock edge
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_sr           <= 16'h0000;
			bit_cnt         <= 4'h0;
			frame_valid_out <= 1'b0;
			frame_word_out  <= 16'h0000;
		end else begin
			frame_valid_out <= 1'b0;
			if (cs_n_in) begin
				bit_cnt <= 4'h0;
			end else if (sclk_rise) begin
				rx_sr   <= {rx_sr[14:0], mosi_in};
				bit_cnt <= bit_cnt + 4'h1;
				if (bit_cnt == 4'(FRAME_BITS - 1)) begin
					frame_valid_out <= 1'b1;
					frame_word_out  <= {rx_sr[14:0], mosi_in};
				end
			end
		end
	end

	// Drive on falling clock edge, reload at select
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_sr    <= 16'h0000;
			miso_out <= 1'b0;
		end else if (cs_n_q && !cs_n_in) begin
			tx_sr <= tx_word_in;
		end else if (!cs_n_in && sclk_fall) begin
			miso_out <= tx_sr[15];
			tx_sr    <= {tx_sr[14:0], 1'b0};
		end
	end

endmodule

/* rtl/rhc_cmd_bit.sv */
// One self-clearing command bit: launch pulse and busy until done
`timescale 1ns/1ns
module rhc_cmd_bit (
	// System
	input  wire logic clk_in,
	input  wire logic nrst_in,
	// Control
	input  wire logic set_in,
	input  wire logic done_in,
	// Status
	output logic      launch_out,
	output logic      busy_out
);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			launch_out <= 1'b0;
			busy_out   <= 1'b0;
		end else begin
			launch_out <= set_in && (!busy_out || done_in);
			if (set_in && (!busy_out || done_in)) begin
				busy_out <= 1'b1;
			end else if (done_in) begin
				busy_out <= 1'b0;
			end
		end
	end

endmodule

/* rtl/rhc_regs.sv */
// Record header, global command and identification registers behind the serial port
`timescale 1ns/1ns
// Operation
// - Temperature is 16-bit offset binary, 4584 is zero, each count -0.0815 C.
// - Header captures time, settings, flags and alarm results per record.
// - Every header register refreshes when a new record completes.
// - Retrieve-record command reloads the header, except temperature, from the fetched stored record.
// - Settings A bits 15:14 hold the sample rate option zero to three.
// - Settings A bits 13:12 hold window: rectangular, Hanning, flat top, none.
// - Settings A bits 11:10 hold range: 1, 5, 10, 20 g.
// - Settings A bits 7:0 hold averages; bits 9:8 unused; reset 0x0008.
// - Settings B bits 3:0 hold the averaging-count setting; reset zero.
// - Relative seconds stamp split into low and high words, reset zero.
// - Writing 1 launches a command; bit self-clears on completion; write-only.
// - Bit 15 clears autonull correction, bit 0 runs autonull.
// - Bit 14 fetches alarm band data, bit 13 fetches a stored record.
// - Bit 12 copies alarm bands to SRAM, bit 9 erases them in flash.
// - Bit 11 toggles recording, bit 10 zeroes the buffer index pointer.
// - Bit 8 clears records and buffers, written with frame 0xB701.
// - Bit 7 soft reset, bit 6 saves to flash, bit 1 powers down.
// - Bit 5 checks flash sum against factory value, result into a flag.
// - Bit 4 clears diagnostic flags, bit 3 restores factory settings.
// - Bit 2 runs self-test, result posted into diagnostic bit 5.
// - Gateway page shows lot words at 0x1A and 0x1C, read-only.
// - Node pages show lot words at 0x68 and 0x6A, read-only.
// - Gateway page shows a fixed part code at 0x16, read-only.
module rhc_regs
	import rhc_pkg::*;
#(
	parameter int unsigned  SEC_CYCLES   = CYCLES_PER_SEC,
	parameter logic [15:0]  PART_CODE    = 16'h5a5a, // Arbitrary value
	parameter logic [15:0]  GW_LOT_ONE   = 16'h1111, // Arbitrary value
	parameter logic [15:0]  GW_LOT_TWO   = 16'h2222, // Arbitrary value
	parameter logic [15:0]  NODE_LOT_ONE = 16'h3333, // Arbitrary value
	parameter logic [15:0]  NODE_LOT_TWO = 16'h4444  // Arbitrary value
)(
	// System
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	// Serial port
	input  wire logic        sclk_in,
	input  wire logic        cs_n_in,
	input  wire logic        mosi_in,
	output logic             miso_out,
	// Record events
	input  wire logic        rec_done_in,
	input  wire logic        fetch_done_in,
	input  wire logic [31:0] stored_seconds_in,
	input  wire logic [15:0] temp_code_in,
	// Header content
	input  wire logic [1:0]  rate_in,
	input  wire logic [1:0]  window_in,
	input  wire logic [1:0]  range_in,
	input  wire logic [7:0]  averages_in,
	input  wire logic [3:0]  avg_setting_in,
	input  wire logic [15:0] diag_in,
	input  wire logic [15:0] x_flags_in,
	input  wire logic [15:0] y_flags_in,
	input  wire logic [15:0] x_peak_in,
	input  wire logic [15:0] y_peak_in,
	input  wire logic [15:0] x_bin_in,
	input  wire logic [15:0] y_bin_in,
	// Command completion
	input  wire logic [15:0] cmd_done_in,
	input  wire logic        selftest_fail_in,
	input  wire logic        flash_fail_in,
	// Command outputs
	output logic [15:0]      cmd_start_out,
	output logic [15:0]      cmd_busy_out,
	output logic             recording_out,
	output logic [3:0]       record_index_pointer_out
);

	logic [15:0] node_temperature_out;
	logic [15:0] node_diagnostic_flags;
	logic [15:0] x_alarm_flags;
	logic [15:0] y_alarm_flags;
	logic [15:0] x_alarm_peak_value;
	logic [15:0] y_alarm_peak_value;
	logic [15:0] x_alarm_peak_bin;
	logic [15:0] y_alarm_peak_bin;
	logic [15:0] record_seconds_low;
	logic [15:0] record_seconds_high;
	logic [15:0] record_settings_a;
	logic [15:0] record_settings_b;
	logic [7:0]  page;
	logic [31:0] sec_cnt;
	logic [31:0] tick_cnt;
	logic [15:0] rd_word;
	logic [15:0] next_rd_word;
	logic        frame_valid;
	logic [15:0] frame_word;
	logic        frame_wr;
	logic [6:0]  frame_addr;
	logic [6:0]  word_addr;
	logic [15:0] cmd_set;
	logic [15:0] cmd_done_all;
	logic        hdr_load;
	logic [15:0] settings_a_new;

	rhc_spi_frame u_spi (
		.clk_in          (clk_in),
		.nrst_in         (nrst_in),
		.sclk_in         (sclk_in),
		.cs_n_in         (cs_n_in),
		.mosi_in         (mosi_in),
		.miso_out        (miso_out),
		.tx_word_in      (rd_word),
		.frame_valid_out (frame_valid),
		.frame_word_out  (frame_word)
	);

	assign frame_wr   = frame_word[FRAME_WR_BIT];
	assign frame_addr = frame_word[FRAME_ADDR_HI:FRAME_ADDR_LO];
	assign word_addr  = {frame_addr[6:1], 1'b0};
	assign hdr_load   = rec_done_in || fetch_done_in;

	// Byte writes to the command word launch bits
	always_comb begin
		cmd_set = 16'h0000;
		if (frame_valid && frame_wr && word_addr == ADDR_GLOB_CMD) begin
			if (frame_addr[0]) begin
				cmd_set = {frame_word[7:0], 8'h00};
			end else begin
				cmd_set = {8'h00, frame_word[7:0]};
			end
		end
	end

	// Bits 4 and 11 complete at once, bit 13 on fetch done; others wait for their engine
	always_comb begin
		cmd_done_all                   = cmd_done_in;
		cmd_done_all[CMD_DIAG_CLEAR]   = cmd_start_out[CMD_DIAG_CLEAR];
		cmd_done_all[CMD_REC_TOGGLE]   = cmd_start_out[CMD_REC_TOGGLE];
		cmd_done_all[CMD_REC_FETCH]    = fetch_done_in;
	end

	// Every command bit launches and self-clears
	for (genvar b = 0; b < 16; b++) begin : g_cmd
		rhc_cmd_bit u_bit (
			.clk_in     (clk_in),
			.nrst_in    (nrst_in),
			.set_in     (cmd_set[b]),
			.done_in    (cmd_done_all[b]),
			.launch_out (cmd_start_out[b]),
			.busy_out   (cmd_busy_out[b])
		);
	end

	// Recording start and stop
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			recording_out <= 1'b0;
		end else if (cmd_start_out[CMD_REC_TOGGLE]) begin
			recording_out <= !recording_out;
		end
	end

	// Page select and record index pointer
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			page                     <= PAGE_GATEWAY;
			record_index_pointer_out <= 4'h0;
		end else if (frame_valid && frame_wr) begin
			if (frame_addr == ADDR_PAGE) begin
				page <= frame_word[7:0];
			end
			if (frame_addr == ADDR_REC_PTR && page != PAGE_GATEWAY) begin
				record_index_pointer_out <= frame_word[3:0];
			end
		end
	end

	// Relative seconds
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tick_cnt <= 32'h0000_0000;
			sec_cnt  <= 32'h0000_0000;
		end else if (tick_cnt == SEC_CYCLES - 1) begin
			tick_cnt <= 32'h0000_0000;
			sec_cnt  <= sec_cnt + 32'h0000_0001;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end

	// Temperature taken at the end of each new record
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			node_temperature_out <= TEMP_ZERO_CODE;
		end else if (rec_done_in) begin
			node_temperature_out <= temp_code_in;
		end
	end

	always_comb begin
		settings_a_new                                = 16'h0000;
		settings_a_new[SET_RATE_LO +: 2]              = rate_in;
		settings_a_new[SET_WIN_LO +: 2]               = window_in;
		settings_a_new[SET_RANGE_LO +: 2]             = range_in;
		settings_a_new[SET_AVG_LO +: 8]               = averages_in;
	end

	// Header capture, new record or stored record
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			x_alarm_flags       <= 16'h0000;
			y_alarm_flags       <= 16'h0000;
			x_alarm_peak_value  <= 16'h0000;
			y_alarm_peak_value  <= 16'h0000;
			x_alarm_peak_bin    <= 16'h0000;
			y_alarm_peak_bin    <= 16'h0000;
			record_seconds_low  <= RST_SECONDS;
			record_seconds_high <= RST_SECONDS;
			record_settings_a   <= RST_SET_A;
			record_settings_b   <= RST_SET_B;
		end else if (hdr_load) begin
			x_alarm_flags      <= x_flags_in;
			y_alarm_flags      <= y_flags_in;
			x_alarm_peak_value <= x_peak_in;
			y_alarm_peak_value <= y_peak_in;
			x_alarm_peak_bin   <= x_bin_in;
			y_alarm_peak_bin   <= y_bin_in;
			record_settings_a  <= settings_a_new;
			record_settings_b  <= {12'h000, avg_setting_in};
			if (fetch_done_in) begin
				record_seconds_low  <= stored_seconds_in[15:0];
				record_seconds_high <= stored_seconds_in[31:16];
			end else begin
				record_seconds_low  <= sec_cnt[15:0];
				record_seconds_high <= sec_cnt[31:16];
			end
		end
	end

	// Diagnostic flags: test results set, clear command clears, set wins
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			node_diagnostic_flags <= 16'h0000;
		end else begin
			if (hdr_load) begin
				node_diagnostic_flags <= diag_in;
			end else if (cmd_start_out[CMD_DIAG_CLEAR]) begin
				node_diagnostic_flags <= 16'h0000;
			end
			if (cmd_done_in[CMD_SELF_TEST] && cmd_busy_out[CMD_SELF_TEST]) begin
				node_diagnostic_flags[DIAG_SELF_TEST] <= selftest_fail_in;
			end
			if (cmd_done_in[CMD_FLASH_TEST] && cmd_busy_out[CMD_FLASH_TEST]) begin
				node_diagnostic_flags[DIAG_FLASH_TEST] <= flash_fail_in;
			end
		end
	end

	// Read decode; the command word reads as zero
	always_comb begin
		next_rd_word = 16'h0000;
		if (frame_addr[6:1] == ADDR_PAGE[6:1]) begin
			next_rd_word = {8'h00, page};
		end else if (page == PAGE_GATEWAY) begin
			case (word_addr)
				ADDR_GW_PART:  next_rd_word = PART_CODE;
				ADDR_GW_LOT_1: next_rd_word = GW_LOT_ONE;
				ADDR_GW_LOT_2: next_rd_word = GW_LOT_TWO;
				default:       next_rd_word = 16'h0000;
			endcase
		end else if (page <= PAGE_NODE_LAST) begin
			case (word_addr)
				ADDR_TEMP:       next_rd_word = node_temperature_out;
				ADDR_REC_PTR:    next_rd_word = {12'h000, record_index_pointer_out};
				ADDR_DIAG:       next_rd_word = node_diagnostic_flags;
				ADDR_X_FLAGS:    next_rd_word = x_alarm_flags;
				ADDR_Y_FLAGS:    next_rd_word = y_alarm_flags;
				ADDR_X_PEAK:     next_rd_word = x_alarm_peak_value;
				ADDR_Y_PEAK:     next_rd_word = y_alarm_peak_value;
				ADDR_SEC_LOW:    next_rd_word = record_seconds_low;
				ADDR_SEC_HIGH:   next_rd_word = record_seconds_high;
				ADDR_X_BIN:      next_rd_word = x_alarm_peak_bin;
				ADDR_Y_BIN:      next_rd_word = y_alarm_peak_bin;
				ADDR_SET_A:      next_rd_word = record_settings_a;
				ADDR_SET_B:      next_rd_word = record_settings_b;
				ADDR_NODE_LOT_1: next_rd_word = NODE_LOT_ONE;
				ADDR_NODE_LOT_2: next_rd_word = NODE_LOT_TWO;
				default:         next_rd_word = 16'h0000;
			endcase
		end
	end

	// Answer of a read frame is shifted out in the next frame
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_word <= 16'h0000;
		end else if (frame_valid && !frame_wr) begin
			rd_word <= next_rd_word;
		end
	end

	property p_temp;
		@(posedge clk_in) disable iff (!nrst_in)
		rec_done_in |=> node_temperature_out == $past(temp_code_in);
	endproperty
	a_temp: assert property (p_temp) else $error("temperature not latched");
	property p_header;
		@(posedge clk_in) disable iff (!nrst_in)
		hdr_load |=> x_alarm_flags == $past(x_flags_in) && y_alarm_peak_bin == $past(y_bin_in)
			&& record_settings_b == {12'h000, $past(avg_setting_in)};
	endproperty
	a_header: assert property (p_header) else $error("stale header");
	property p_fetch;
		@(posedge clk_in) disable iff (!nrst_in)
		fetch_done_in |=> {record_seconds_high, record_seconds_low} == $past(stored_seconds_in)
			&& !cmd_busy_out[CMD_REC_FETCH];
	endproperty
	a_fetch: assert property (p_fetch) else $error("stored record not loaded");
	property p_settings;
		@(posedge clk_in) disable iff (!nrst_in)
		hdr_load |=> record_settings_a[15:14] == $past(rate_in)
			&& record_settings_a[13:12] == $past(window_in)
			&& record_settings_a[11:10] == $past(range_in) && record_settings_a[9:8] == 2'b00
			&& record_settings_a[7:0] == $past(averages_in);
	endproperty
	a_settings: assert property (p_settings) else $error("bad fields");
	property p_stamp;
		@(posedge clk_in) disable iff (!nrst_in)
		(rec_done_in && !fetch_done_in)
			|=> {record_seconds_high, record_seconds_low} == $past(sec_cnt);
	endproperty
	a_stamp: assert property (p_stamp) else $error("time stamp halves wrong");
	property p_launch;
		@(posedge clk_in) disable iff (!nrst_in)
		(cmd_set[CMD_CLEAR_RECS] && !cmd_busy_out[CMD_CLEAR_RECS])
			|=> cmd_start_out[CMD_CLEAR_RECS] ##1 !cmd_start_out[CMD_CLEAR_RECS];
	endproperty
	a_launch: assert property (p_launch) else $error("launch not single");
	property p_selfclear;
		@(posedge clk_in) disable iff (!nrst_in)
		(cmd_busy_out[CMD_SAVE_FLASH] && cmd_done_in[CMD_SAVE_FLASH] && !cmd_set[CMD_SAVE_FLASH])
			|=> !cmd_busy_out[CMD_SAVE_FLASH];
	endproperty
	a_selfclear: assert property (p_selfclear) else $error("bit not cleared");
	property p_diag_clear;
		@(posedge clk_in) disable iff (!nrst_in)
		(cmd_start_out[CMD_DIAG_CLEAR] && !hdr_load && !cmd_done_in[CMD_SELF_TEST]
			&& !cmd_done_in[CMD_FLASH_TEST]) |=> node_diagnostic_flags == 16'h0000;
	endproperty
	a_diag_clear: assert property (p_diag_clear) else $error("flags not cleared");
	property p_selftest;
		@(posedge clk_in) disable iff (!nrst_in)
		(cmd_done_in[CMD_SELF_TEST] && cmd_busy_out[CMD_SELF_TEST])
			|=> node_diagnostic_flags[DIAG_SELF_TEST] == $past(selftest_fail_in);
	endproperty
	a_selftest: assert property (p_selftest) else $error("self-test result lost");
	property p_toggle;
		@(posedge clk_in) disable iff (!nrst_in)
		cmd_start_out[CMD_REC_TOGGLE] |=> recording_out != $past(recording_out);
	endproperty
	a_toggle: assert property (p_toggle) else $error("recording did not toggle");
	property p_part;
		@(posedge clk_in) disable iff (!nrst_in)
		(frame_valid && !frame_wr && page == PAGE_GATEWAY && frame_addr == ADDR_GW_PART)
			|=> rd_word == PART_CODE;
	endproperty
	a_part: assert property (p_part) else $error("part code not returned");

endmodule

/* sim/rhc_host.sv */
// Host serial master model: mode 3, one 16-bit frame per call
`timescale 1ns/1ns
module rhc_host (
	// System
	input  wire logic clk_in,
	// Serial pins
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      mosi_out,
	input  wire logic miso_in
);
	initial begin
		sclk_out = 1'b1;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	task automatic tk(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Released data line shows the inverse of its last bit
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		cs_n_out = 1'b0;
		tk(4);
		for (int i = 15; i >= 0; i--) begin
			sclk_out = 1'b0;
			mosi_out = w[i];
			tk(4);
			sclk_out = 1'b1;
			r[i] = miso_in;
			tk(4);
		end
		cs_n_out = 1'b1;
		mosi_out = ~mosi_out;
		tk(4);
	endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the record header and command registers
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t mismatch %h vs %h", $time, (a), (e)); end end
module testbench;
	import rhc_pkg::*;
	logic        clk_in, nrst_in, rec_done, fetch_done, st_fail, fl_fail, rec_on;
	logic [1:0]  rate, window, range;
	logic [7:0]  averages;
	logic [3:0]  avg_set, rip;
	logic [15:0] temp, diag, xf, yf, xp, yp, xb, yb, done, start, busy, last, v;
	logic [31:0] stored;
	wire         sclk, cs_n, mosi, miso;
	int          num_errors, total_checks, nstart, cyc, n0;
	logic [30:0] rows [13] = '{
		{8'h01, ADDR_TEMP, 16'h11e8}, {8'h01, ADDR_SET_A, 16'h0008},
		{8'h01, ADDR_SET_B, 16'h0000}, {8'h01, ADDR_SEC_LOW, 16'h0000},
		{8'h01, ADDR_SEC_HIGH, 16'h0000}, {8'h01, ADDR_DIAG, 16'h0000},
		{8'h01, ADDR_NODE_LOT_1, 16'h3333}, {8'h01, ADDR_NODE_LOT_2, 16'h4444},
		{8'h01, 7'h50, 16'h0000}, {8'h00, ADDR_GW_PART, 16'h5a5a},
		{8'h00, ADDR_GW_LOT_1, 16'h1111}, {8'h00, ADDR_GW_LOT_2, 16'h2222},
		{8'h07, ADDR_TEMP, 16'h0000}};

	rhc_regs #(.SEC_CYCLES(10)) dut_u (
		.clk_in(clk_in), .nrst_in(nrst_in), .sclk_in(sclk), .cs_n_in(cs_n),
		.mosi_in(mosi), .miso_out(miso), .rec_done_in(rec_done),
		.fetch_done_in(fetch_done), .stored_seconds_in(stored), .temp_code_in(temp),
		.rate_in(rate), .window_in(window), .range_in(range), .averages_in(averages),
		.avg_setting_in(avg_set), .diag_in(diag), .x_flags_in(xf), .y_flags_in(yf),
		.x_peak_in(xp), .y_peak_in(yp), .x_bin_in(xb), .y_bin_in(yb),
		.cmd_done_in(done), .selftest_fail_in(st_fail), .flash_fail_in(fl_fail),
		.cmd_start_out(start), .cmd_busy_out(busy), .recording_out(rec_on),
		.record_index_pointer_out(rip));
	rhc_host host_u (.clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n),
		.mosi_out(mosi), .miso_in(miso));

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	// Launch pulse counter and timeout
	always @(posedge clk_in) begin
		cyc++;
		if (start != 16'h0) begin
			nstart++;
			last = start;
		end
		if (cyc == 90000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host_u.xfer({1'b1, a, d}, v);
	endtask
	// Read answer arrives in the following frame
	task automatic rd(input logic [6:0] a);
		host_u.xfer({1'b0, a, 8'h00}, v);
		host_u.xfer(16'h0000, v);
	endtask
	task automatic load(input logic [15:0] s);
		{rate, window, range} = {3{s[1:0]}};
		averages = (s[1:0] == 2'd3) ? 8'hff : s[7:0];
		avg_set = s[3:0] ^ 4'ha;
		{temp, diag, xf, yf} = {s, s ^ 16'h0a00, ~s, s + 16'h1};
		{xp, yp, xb, yb} = {s ^ 16'h5555, s << 1, s ^ 16'h00ff, s >> 1};
	endtask
	task automatic hdr(input logic tchk);
		logic [6:0]  ad [8];
		logic [15:0] ex [8];
		ad = '{ADDR_DIAG, ADDR_X_FLAGS, ADDR_Y_FLAGS, ADDR_X_PEAK, ADDR_Y_PEAK,
			ADDR_X_BIN, ADDR_Y_BIN, ADDR_TEMP};
		ex = '{diag, xf, yf, xp, yp, xb, yb, temp};
		for (int i = 0; i < (tchk ? 8 : 7); i++) begin
			rd(ad[i]);
			`CHK(v, ex[i])
		end
		rd(ADDR_SET_A);
		`CHK(v & 16'hfcff, {rate, window, range, 2'b00, averages})
		rd(ADDR_SET_B);
		`CHK(v[3:0], avg_set)
	endtask

	initial begin
		nrst_in = 1'b0;
		{rec_done, fetch_done, st_fail, fl_fail, done, stored} = '0;
		load(16'h0);
		tk(6);
		nrst_in = 1'b1;
		tk(2);
		wr(ADDR_SET_A, 8'hff);
		foreach (rows[i]) begin
			wr(ADDR_PAGE, rows[i][30:23]);
			rd(rows[i][22:16]);
			`CHK(v, rows[i][15:0])
		end
		$display("test reset and identity done");
		wr(ADDR_PAGE, 8'h01);
		for (int k = 0; k < 4; k++) begin
			load(16'h1230 + 16'(k));
			rec_done = 1'b1;
			tk(1);
			rec_done = 1'b0;
			tk(1);
			hdr(1'b1);
		end
		rd(ADDR_SEC_HIGH);
		`CHK(v, 16'h0000)
		rd(ADDR_SEC_LOW);
		`CHK(v > 16'd100, 1'b1)
		$display("test record header done");
		// Self-test passes so the stale bit 5 from the last header is seen to be overwritten with zero
		{st_fail, fl_fail} = 2'b01;
		for (int b = 0; b < 16; b++) begin
			if (b == 13) begin
				wr(ADDR_REC_PTR, 8'h0a);
				`CHK(rip, 4'ha)
				load(16'h4c67);
				stored = 32'h1234_5678;
			end
			n0 = nstart;
			// Write 1 to command bit b through its byte of the command word
			wr(ADDR_GLOB_CMD + 7'(b / 8), 8'(1 << (b % 8)));
			`CHK(last, 16'(1 << b))
			if (b != 4 && b != 11) begin
				`CHK(busy, 16'(1 << b))
				wr(ADDR_GLOB_CMD + 7'(b / 8), 8'(1 << (b % 8)));
				`CHK(nstart, n0 + 1)
			end
			{done[b], fetch_done} = {b != 13, b == 13};
			tk(1);
			{done, fetch_done} = '0;
			tk(2);
			`CHK(busy, 16'h0)
			if (b inside {2, 4, 5}) rd(ADDR_DIAG);
			if (b == 2) `CHK(v[5], 1'b0)
			if (b == 4) `CHK(v, 16'h0000)
			if (b == 5) `CHK(v[6], 1'b1)
			if (b == 11) `CHK(rec_on, 1'b1)
			if (b == 13) begin
				hdr(1'b0);
				rd(ADDR_SEC_LOW);
				`CHK(v, 16'h5678)
				rd(ADDR_SEC_HIGH);
				`CHK(v, 16'h1234)
			end
		end
		$display("test global commands done");
		// Reset in mid-run clears recording, pointer and header
		nrst_in = 1'b0;
		tk(2);
		`CHK({busy, rec_on, rip}, 21'h0_0000)
		nrst_in = 1'b1;
		tk(2);
		wr(ADDR_PAGE, 8'h01);
		rd(ADDR_SET_A);
		`CHK(v, RST_SET_A)
		$display("test mid-run reset done");
		summarize();
	end
endmodule
